/* hdl/sft_pkg.sv */
// shared constants and types of the frame transmitter
`default_nettype none
package sft_pkg;
  // ==========================================
  // register map and field layout
  localparam int REG_W = 26;
  localparam logic [7:0] OFS_CUSTOMER_IDENTIFIER = 8'h02;
  localparam logic [7:0] OFS_OUTPUT_CONFIG = 8'h14;
  localparam logic [7:0] OFS_ERROR_STATUS = 8'h45;
  localparam int MODE_LSB = 0;
  localparam int RATE_LSB = 3;
  localparam int SCN_LSB = 7;
  localparam int DCFG_LSB = 9;
  localparam int ERR_LSB = 16;
  // ==========================================
  // modes and states
  typedef enum logic [2:0] {
    MODE_PWM = 3'h0, MODE_STD = 3'h1, MODE_TRIG_A = 3'h2, MODE_SEQ_LONG = 3'h3,
    MODE_SEQ_SHORT = 3'h4, MODE_ADDR = 3'h5, MODE_TRIG_B = 3'h6, MODE_TRIG_C = 3'h7
  } sft_mode_t;
  typedef enum logic [1:0] {
    SCN_SSM_A = 2'h0, SCN_ZERO = 2'h1, SCN_DIE = 2'h2, SCN_SSM_B = 2'h3
  } sft_scn_t;
  typedef enum logic {ST_IDLE = 1'b0, ST_RUN = 1'b1} sft_state_t;
  // ==========================================
  // frame timing in ticks, checksum seed and polynomial, last serial bit position
  localparam logic [9:0] LOW_TICKS = 10'h005;
  localparam logic [9:0] SYNC_TICKS = 10'h038;
  localparam logic [9:0] NIB_BASE = 10'h00C;
  localparam logic [9:0] PAUSE_MIN = 10'h00C;
  localparam int FRAME_TICKS = 300;
  localparam logic [3:0] CRC_SEED = 4'h5;
  localparam logic [3:0] CRC_POLY = 4'hD;
  localparam logic [3:0] SSM_LAST = 4'hF;
  // ==========================================
  // clock based counts
  localparam int CLK_NS = 8;
  localparam int TICK_STEP_NS = 500;
  localparam int TICK_STEP_CYC = (TICK_STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int TRIG_LONG_NS = 12000;
  localparam int TRIG_LONG_CYC = (TRIG_LONG_NS + CLK_NS - 1) / CLK_NS;
  localparam int TRIG_GAP_NS = 30000;
  localparam int TRIG_GAP_CYC = (TRIG_GAP_NS + CLK_NS - 1) / CLK_NS;
endpackage
`default_nettype wire

/* hdl/sft_stream_if.sv */
// valid/ready word stream between fifo and frame logic
`timescale 1ns/1ps
`default_nettype none
interface sft_stream_if #(parameter int W = 16);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src(output data, output valid, input ready);
  modport snk(input data, input valid, output ready);
endinterface
`default_nettype wire

/* hdl/sft_fifo.sv */
// sample fifo ahead of the frame builder
`timescale 1ns/1ps
`default_nettype none
module sft_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 32
)(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  sft_stream_if.src out
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("fifo depth must be a power of two");
  end
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0] cnt_ff;
  logic [AW:0] nxt_cnt;
  logic not_full_ff;
  logic push;
  logic pop;
  assign push = in_valid && not_full_ff;
  assign pop = out.valid && out.ready;
  assign out.valid = cnt_ff != '0;
  assign out.data = mem[rd_ff];
  assign in_ready = not_full_ff;
  assign nxt_cnt = (AW + 1)'(cnt_ff + (AW + 1)'(push) - (AW + 1)'(pop));
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ff] <= in_data;
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
      not_full_ff <= 1'b0;
    end else begin
      wr_ff <= AW'(wr_ff + AW'(push));
      rd_ff <= AW'(rd_ff + AW'(pop));
      cnt_ff <= nxt_cnt;
      not_full_ff <= nxt_cnt != (AW + 1)'(DEPTH);
    end
  end
endmodule
`default_nettype wire

/* hdl/sft_crc.sv */
// four bit nibble checksum
`timescale 1ns/1ps
`default_nettype none
module sft_crc #(
  parameter int N = 6
)(
  input wire logic [4*N-1:0] nibs,
  input wire logic [3:0] cnt,
  output logic [3:0] crc
);
  if (N < 1 || N > 15) begin : g_chk
    $error("nibble count out of range");
  end
  // first nibble sits in the top bits, one zero nibble is appended
  always_comb begin
    logic [3:0] c;
    logic [4*N-1:0] sh;
    logic b;
    logic fb;
    c = sft_pkg::CRC_SEED;
    sh = nibs;
    b = 1'b0;
    fb = 1'b0;
    for (int i = 0; i <= N; i++) begin
      for (int j = 0; j < 4; j++) begin
        b = (i < int'(cnt)) ? sh[4*N-1] : 1'b0;
        sh = sh << 1;
        if (i <= int'(cnt)) begin
          fb = c[3];
          c = {c[2:0], b} ^ (fb ? sft_pkg::CRC_POLY : 4'h0);
        end
      end
    end
    crc = c;
  end
endmodule
`default_nettype wire

/* hdl/sft_top.sv */
// single wire nibble frame transmitter with trigger modes and slow serial channel
`timescale 1ns/1ps
`default_nettype none
module sft_top #(
  parameter int DEPTH = 32,
  parameter int FRAME_TICKS = sft_pkg::FRAME_TICKS
)(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [15:0] mag_data,
  input wire logic mag_valid,
  output logic mag_ready,
  input wire logic [25:0] customer_identifier,
  input wire logic [25:0] output_config,
  input wire logic [25:0] error_status,
  input wire logic [11:0] temp_value,
  input wire logic soft_err,
  input wire logic hard_err,
  input wire logic [1:0] die_addr,
  input wire logic line_in,
  output logic line_o,
  output logic line_oe
);
  if (FRAME_TICKS < 100 || FRAME_TICKS > 1023 || 16 * sft_pkg::TICK_STEP_CYC > 1023) begin : g_chk
    $error("frame or tick length out of range");
  end

  // ==========================================
  // configuration decode
  sft_pkg::sft_mode_t mode;
  sft_pkg::sft_scn_t scn;
  logic [3:0] rate;
  logic [2:0] dcfg;
  logic [7:0] diag;
  logic ssm_en;
  logic continuous;
  logic trig_any;
  logic [9:0] tick_len;
  assign mode = sft_pkg::sft_mode_t'(output_config[sft_pkg::MODE_LSB +: 3]);
  assign rate = output_config[sft_pkg::RATE_LSB +: 4];
  assign scn = sft_pkg::sft_scn_t'(output_config[sft_pkg::SCN_LSB +: 2]);
  assign dcfg = output_config[sft_pkg::DCFG_LSB +: 3];
  assign diag = error_status[sft_pkg::ERR_LSB +: 8];
  assign ssm_en = scn == sft_pkg::SCN_SSM_A || scn == sft_pkg::SCN_SSM_B;
  assign continuous = mode == sft_pkg::MODE_STD;
  assign trig_any = mode == sft_pkg::MODE_TRIG_A || mode == sft_pkg::MODE_TRIG_B
    || mode == sft_pkg::MODE_TRIG_C;
  assign tick_len = 10'((rate + 5'h01) * 10'(sft_pkg::TICK_STEP_CYC));

  // ==========================================
  // registers
  sft_pkg::sft_state_t state_ff;
  logic [9:0] tick_cnt_ff;
  logic [9:0] sub_ff;
  logic [3:0] idx_ff;
  logic [9:0] ftick_ff;
  logic [15:0] mag_ff;
  logic [23:0] nib_ff;
  logic [2:0] ndata_ff;
  logic [3:0] status_ff;
  logic [11:0] fcnt_ff;
  logic [3:0] ssm_pos_ff;
  logic [3:0] ssm_id_ff;
  logic line_oe_ff;
  logic line_o_ff;
  logic trig_fire_ff;
  logic prev_in_ff;
  logic [11:0] low_cnt_ff;
  logic [11:0] gap_cnt_ff;
  logic [2:0] pulse_cnt_ff;

  // ==========================================
  // sample fifo
  sft_stream_if #(.W(16)) strm ();
  sft_fifo #(.W(16), .DEPTH(DEPTH)) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .in_data(mag_data),
    .in_valid(mag_valid),
    .in_ready(mag_ready),
    .out(strm.src)
  );

  // ==========================================
  // frame control
  logic tick;
  logic start;
  logic nib_end;
  logic is_pause;
  logic pause_done;
  logic frame_end;
  logic [9:0] nib_len;
  logic [3:0] crc_idx;
  logic [2:0] sel;
  logic [23:0] nib_sh;
  logic [3:0] frame_crc;
  logic [15:0] cur_mag;
  assign tick = state_ff == sft_pkg::ST_RUN && tick_cnt_ff == 10'(tick_len - 10'h001);
  assign start = state_ff == sft_pkg::ST_IDLE && (continuous || trig_fire_ff);
  assign strm.ready = start;
  assign cur_mag = strm.valid ? strm.data : mag_ff;
  assign crc_idx = 4'(ndata_ff + 4'h2);
  assign sel = 3'(idx_ff - 4'h2);
  assign nib_sh = nib_ff << {sel, 2'b00};
  assign is_pause = idx_ff > crc_idx;
  assign pause_done = sub_ff >= 10'(sft_pkg::PAUSE_MIN - 10'h001)
    && (!continuous || int'(ftick_ff) >= FRAME_TICKS - 1);
  assign nib_end = tick && (is_pause ? pause_done : sub_ff == 10'(nib_len - 10'h001));
  assign frame_end = nib_end && is_pause;

  // nibble length in ticks, in frame order
  always_comb begin
    if (idx_ff == 4'h0) begin
      nib_len = sft_pkg::SYNC_TICKS;
    end else if (idx_ff == 4'h1) begin
      nib_len = 10'(sft_pkg::NIB_BASE + 10'(status_ff));
    end else if (idx_ff < crc_idx) begin
      nib_len = 10'(sft_pkg::NIB_BASE + 10'(nib_sh[23:20]));
    end else begin
      nib_len = 10'(sft_pkg::NIB_BASE + 10'(frame_crc));
    end
  end

  // frame checksum over the data nibbles only
  sft_crc #(.N(6)) u_frame_crc (
    .nibs(nib_ff),
    .cnt({1'b0, ndata_ff}),
    .crc(frame_crc)
  );

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_ff <= sft_pkg::ST_IDLE;
    end else begin
      case (state_ff)
        sft_pkg::ST_IDLE: begin
          if (start) begin
            state_ff <= sft_pkg::ST_RUN;
          end
        end
        sft_pkg::ST_RUN: begin
          if (frame_end) begin
            state_ff <= sft_pkg::ST_IDLE;
          end
        end
        default: begin
          state_ff <= sft_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // tick divider, held at zero between frames
  always_ff @(posedge clk) begin
    if (!rstn || state_ff == sft_pkg::ST_IDLE) begin
      tick_cnt_ff <= 10'h000;
    end else if (tick) begin
      tick_cnt_ff <= 10'h000;
    end else begin
      tick_cnt_ff <= 10'(tick_cnt_ff + 10'h001);
    end
  end

  // position within the nibble and within the frame
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sub_ff <= 10'h000;
      idx_ff <= 4'h0;
      ftick_ff <= 10'h000;
    end else if (start) begin
      sub_ff <= 10'h000;
      idx_ff <= 4'h0;
      ftick_ff <= 10'h000;
    end else begin
      if (nib_end) begin
        sub_ff <= 10'h000;
        idx_ff <= 4'(idx_ff + 4'h1);
      end else if (tick) begin
        sub_ff <= 10'(sub_ff + 10'h001);
      end
      if (tick) begin
        ftick_ff <= 10'(ftick_ff + 10'h001);
      end
    end
  end

  // ==========================================
  // data nibbles
  logic [23:0] nxt_nib;
  logic [2:0] nxt_ndata;
  always_comb begin
    case (dcfg)
      3'h0: begin
        nxt_nib = {cur_mag[15:4], 12'h000};
        nxt_ndata = 3'h3;
      end
      3'h1: begin
        nxt_nib = {cur_mag[15:4], diag, fcnt_ff[3:0]};
        nxt_ndata = 3'h6;
      end
      3'h2: begin
        nxt_nib = {cur_mag[15:4], fcnt_ff};
        nxt_ndata = 3'h6;
      end
      3'h3: begin
        nxt_nib = {cur_mag[15:4], temp_value};
        nxt_ndata = 3'h6;
      end
      3'h4: begin
        nxt_nib = {cur_mag, 8'h00};
        nxt_ndata = 3'h4;
      end
      3'h5: begin
        nxt_nib = {cur_mag, diag};
        nxt_ndata = 3'h6;
      end
      3'h6: begin
        nxt_nib = {cur_mag, fcnt_ff[7:0]};
        nxt_ndata = 3'h6;
      end
      default: begin
        nxt_nib = {cur_mag, temp_value[11:4]};
        nxt_ndata = 3'h6;
      end
    endcase
  end

  // ==========================================
  // slow serial channel and status nibble
  logic [7:0] ssm_data;
  logic [3:0] ssm_crc;
  logic [15:0] ssm_word;
  logic ssm_bit;
  logic [3:0] nxt_status;
  always_comb begin
    case (ssm_id_ff)
      4'h0: ssm_data = temp_value[10:3];
      4'h1: ssm_data = diag;
      4'h2: ssm_data = customer_identifier[7:0];
      4'h3: ssm_data = customer_identifier[15:8];
      4'h4: ssm_data = {2'b00, customer_identifier[21:16]};
      default: ssm_data = 8'h00;
    endcase
  end

  sft_crc #(.N(3)) u_ssm_crc (
    .nibs({ssm_id_ff, ssm_data}),
    .cnt(4'h3),
    .crc(ssm_crc)
  );

  assign ssm_word = {ssm_id_ff, ssm_data, ssm_crc};
  assign ssm_bit = ssm_word[4'(sft_pkg::SSM_LAST - ssm_pos_ff)];

  always_comb begin
    case (scn)
      sft_pkg::SCN_ZERO: nxt_status = {2'b00, soft_err, hard_err};
      sft_pkg::SCN_DIE: nxt_status = {die_addr, soft_err, hard_err};
      default: nxt_status = {ssm_pos_ff == 4'h0, ssm_bit, soft_err, hard_err};
    endcase
  end

  // one status bit pair per frame, the receiver assembles the message
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ssm_pos_ff <= 4'h0;
      ssm_id_ff <= 4'h0;
    end else if (start && ssm_en) begin
      ssm_pos_ff <= 4'(ssm_pos_ff + 4'h1);
      if (ssm_pos_ff == sft_pkg::SSM_LAST) begin
        ssm_id_ff <= 4'(ssm_id_ff + 4'h1);
      end
    end
  end

  // frame contents are frozen at the frame start
  always_ff @(posedge clk) begin
    if (!rstn) begin
      mag_ff <= 16'h0000;
      nib_ff <= 24'h000000;
      ndata_ff <= 3'h3;
      status_ff <= 4'h0;
      fcnt_ff <= 12'h000;
    end else if (start) begin
      mag_ff <= cur_mag;
      nib_ff <= nxt_nib;
      ndata_ff <= nxt_ndata;
      status_ff <= nxt_status;
      fcnt_ff <= 12'(fcnt_ff + 12'h001);
    end
  end

  // ==========================================
  // open drain line: pulled low for the first ticks of every nibble
  always_ff @(posedge clk) begin
    if (!rstn) begin
      line_oe_ff <= 1'b0;
      line_o_ff <= 1'b0;
    end else begin
      line_oe_ff <= state_ff == sft_pkg::ST_RUN && sub_ff < sft_pkg::LOW_TICKS;
      line_o_ff <= 1'b0;
    end
  end
  assign line_oe = line_oe_ff;
  assign line_o = line_o_ff;

  // ==========================================
  // host request detection while the line is idle
  logic rise;
  logic is_long;
  assign rise = line_in && !prev_in_ff;
  assign is_long = int'(low_cnt_ff) >= sft_pkg::TRIG_LONG_CYC;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      prev_in_ff <= 1'b1;
      trig_fire_ff <= 1'b0;
      low_cnt_ff <= 12'h000;
      gap_cnt_ff <= 12'h000;
      pulse_cnt_ff <= 3'h0;
    end else begin
      prev_in_ff <= line_in;
      trig_fire_ff <= 1'b0;
      if (state_ff == sft_pkg::ST_RUN || start) begin
        low_cnt_ff <= 12'h000;
        gap_cnt_ff <= 12'h000;
        pulse_cnt_ff <= 3'h0;
      end else begin
        if (!line_in && low_cnt_ff != 12'hFFF) begin
          low_cnt_ff <= 12'(low_cnt_ff + 12'h001);
        end else if (line_in) begin
          low_cnt_ff <= 12'h000;
        end
        if (rise) begin
          gap_cnt_ff <= 12'h000;
          case (mode)
            sft_pkg::MODE_TRIG_A, sft_pkg::MODE_TRIG_B, sft_pkg::MODE_TRIG_C: trig_fire_ff <= 1'b1;
            sft_pkg::MODE_SEQ_LONG: trig_fire_ff <= is_long;
            sft_pkg::MODE_SEQ_SHORT: trig_fire_ff <= !is_long;
            sft_pkg::MODE_ADDR: pulse_cnt_ff <= 3'(pulse_cnt_ff + 3'h1);
            default: trig_fire_ff <= 1'b0;
          endcase
        end else if (mode == sft_pkg::MODE_ADDR && pulse_cnt_ff != 3'h0 && line_in) begin
          if (int'(gap_cnt_ff) >= sft_pkg::TRIG_GAP_CYC - 1) begin
            trig_fire_ff <= pulse_cnt_ff == 3'({1'b0, die_addr} + 3'h1);
            pulse_cnt_ff <= 3'h0;
            gap_cnt_ff <= 12'h000;
          end else begin
            gap_cnt_ff <= 12'(gap_cnt_ff + 12'h001);
          end
        end
      end
    end
  end

  // ==========================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  logic [12:0] low_run_ff;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      low_run_ff <= 13'h0000;
    end else begin
      low_run_ff <= line_oe_ff ? 13'(low_run_ff + 13'h0001) : 13'h0000;
    end
  end

  sequence s_start;
    state_ff == sft_pkg::ST_IDLE && (continuous || trig_fire_ff);
  endsequence
  sequence s_ssm_first;
    s_start ##0 (ssm_en && ssm_pos_ff == 4'h0);
  endsequence
  sequence s_ssm_wrap;
    s_start ##0 (ssm_en && ssm_pos_ff == sft_pkg::SSM_LAST);
  endsequence

  AST_LOW_FIVE: assert property ($fell(line_oe_ff) |-> low_run_ff == 13'(sft_pkg::LOW_TICKS) * 13'(tick_len))
    else $error("low interval is not five ticks");
  AST_STD_FREE: assert property (continuous && state_ff == sft_pkg::ST_IDLE |=> state_ff == sft_pkg::ST_RUN)
    else $error("standard mode did not start a frame");
  AST_TRIG_WAIT: assert property (trig_any && state_ff == sft_pkg::ST_IDLE && !trig_fire_ff
    |=> state_ff == sft_pkg::ST_IDLE)
    else $error("triggered mode sent without request");
  AST_SEQ_SHORT: assert property (mode == sft_pkg::MODE_SEQ_SHORT && state_ff == sft_pkg::ST_IDLE
    && rise && is_long |=> !trig_fire_ff)
    else $error("long pulse accepted in short trigger mode");
  AST_ADDR_COUNT: assert property (mode == sft_pkg::MODE_ADDR && pulse_cnt_ff == 3'h0 && !rise
    |=> !trig_fire_ff)
    else $error("addressed request fired without pulses");
  AST_SYNC_LEN: assert property (nib_end && idx_ff == 4'h0 |-> sub_ff == 10'(sft_pkg::SYNC_TICKS - 10'h001))
    else $error("sync nibble length wrong");
  AST_STATUS_LEN: assert property (nib_end && idx_ff == 4'h1
    |-> 10'(sub_ff + 10'h001) == 10'(sft_pkg::NIB_BASE + 10'(status_ff)))
    else $error("status nibble length wrong");
  AST_ORDER: assert property (!$stable(idx_ff) |-> idx_ff == 4'($past(idx_ff) + 4'h1) || idx_ff == 4'h0)
    else $error("nibble order skipped");
  AST_SSM_FIRST: assert property (s_ssm_first |=> status_ff[3])
    else $error("start bit missing");
  AST_SSM_WRAP: assert property (s_ssm_wrap |=> ssm_pos_ff == 4'h0 && ssm_id_ff == 4'($past(ssm_id_ff) + 4'h1))
    else $error("message id did not advance");
  AST_DIAG: assert property (s_start |=> status_ff[1:0] == $past({soft_err, hard_err}))
    else $error("diagnostic bits wrong");
  AST_DIE: assert property (s_start ##0 scn == sft_pkg::SCN_DIE |=> status_ff[3:2] == $past(die_addr))
    else $error("die address missing");
  AST_NO_SSM: assert property (s_start ##0 !ssm_en |=> $stable(ssm_pos_ff))
    else $error("serial channel ran while disabled");
endmodule
`default_nettype wire

/* sim/sft_ecu_model.sv */
// receiving controller model on the shared open-drain line
`timescale 1ns/1ps
`default_nettype none
module sft_ecu_model #(
  parameter int T = 63
)(
  input wire logic clk,
  input wire logic line,
  output logic pull
);
  // ==========================================
  // falling edge period and low time capture
  int per_q[$];
  int cnt = 0;
  int low = 0;
  int low_bad = 0;
  logic line_d = 1'b1;
  logic mine = 1'b0;
  initial pull = 1'b0;
  always @(posedge clk) begin
    cnt <= cnt + 1;
    low <= low + 1;
    if (line_d && !line) begin
      per_q.push_back(cnt);
      cnt <= 1;
      low <= 1;
    end
    if (!line_d && line) begin
      if (!mine && low != 5 * T) low_bad <= low_bad + 1;
      mine <= 1'b0;
    end
    line_d <= line;
  end
  // ==========================================
  // host request pulse
  task automatic pulse(input int n);
    @(posedge clk);
    pull <= 1'b1;
    mine <= 1'b1;
    repeat (n) @(posedge clk);
    pull <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* sim/tb.sv */
// bench: fifo fill, free running slow serial frames, trigger modes
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int T = 63;
  localparam int FT = 150;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [15:0] mag_data = 16'h0000;
  logic mag_valid = 1'b0;
  logic [25:0] ocfg = 26'h0000000;
  logic soft_err = 1'b1;
  logic hard_err = 1'b0;
  logic [1:0] die_addr = 2'h2;
  logic mag_ready, line_o, line_oe, pull;
  wire logic line_w;
  int fail_count = 0;
  int checks_done = 0;
  sft_pkg::sft_mode_t md[6] = '{sft_pkg::MODE_TRIG_A, sft_pkg::MODE_TRIG_B, sft_pkg::MODE_TRIG_C,
    sft_pkg::MODE_SEQ_LONG, sft_pkg::MODE_SEQ_SHORT, sft_pkg::MODE_ADDR};
  int bl[6] = '{0, 0, 0, 200, 2000, 200};
  int bn[6] = '{0, 0, 0, 1, 1, 2};
  int gl[6] = '{200, 2000, 200, 2000, 200, 200};
  int gn[6] = '{1, 1, 1, 1, 1, 3};
  assign line_w = (line_oe ? line_o : 1'b1) & !pull;
  always #4 clk = ~clk;
  sft_top #(.DEPTH(32), .FRAME_TICKS(FT)) dut_u (.clk(clk), .rstn(rstn), .mag_data(mag_data),
    .mag_valid(mag_valid), .mag_ready(mag_ready), .customer_identifier(26'h0123456),
    .output_config(ocfg), .error_status(26'h0A50000), .temp_value(12'h400), .soft_err(soft_err),
    .hard_err(hard_err), .die_addr(die_addr), .line_in(line_w), .line_o(line_o), .line_oe(line_oe));
  sft_ecu_model #(.T(T)) ecu_u (.clk(clk), .line(line_w), .pull(pull));
  // ==========================================
  // helpers
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic timeout();
    cmp(32'h1, 32'h0);
    summarize();
  endtask
  function automatic logic [15:0] wd(input int k);
    return {k[3:0], 4'h0, k[3:0] ^ 4'h1, 4'h0};
  endfunction
  function automatic logic [25:0] cfg(input logic [2:0] m, input logic [1:0] s);
    return {17'h00000, s, 4'h0, m};
  endfunction
  function automatic logic [3:0] crc3(input logic [11:0] d);
    logic [3:0] c;
    logic [15:0] s;
    c = 4'h5;
    s = {d, 4'h0};
    for (int b = 15; b >= 0; b--) c = {c[2:0], s[b]} ^ (c[3] ? 4'hD : 4'h0);
    return c;
  endfunction
  task automatic get_per(output int p);
    int i;
    p = 0;
    for (i = 0; i < 12000 && ecu_u.per_q.size() == 0; i++) @(posedge clk);
    if (ecu_u.per_q.size() == 0) timeout();
    else p = ecu_u.per_q.pop_front();
  endtask
  task automatic check_frame(input logic [3:0] st, input logic [15:0] w, input bit fill);
    int p;
    int sum;
    logic [3:0] c;
    c = crc3(w[15:4]);
    sum = 116 + st + w[15:12] + w[11:8] + w[7:4] + c;
    get_per(p);
    cmp(p, 56 * T);
    get_per(p);
    cmp(p, (12 + st) * T);
    get_per(p);
    cmp(p, (12 + w[15:12]) * T);
    get_per(p);
    cmp(p, (12 + w[11:8]) * T);
    get_per(p);
    cmp(p, (12 + w[7:4]) * T);
    get_per(p);
    cmp(p, (12 + c) * T);
    if (fill) begin
      get_per(p);
      cmp(p, ((FT - sum > 12) ? FT - sum : 12) * T + 1);
    end
  endtask
  task automatic quiet(input int n);
    int k;
    k = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      k += (line_oe !== 1'b0) + (line_o !== 1'b0);
    end
    cmp(k, 0);
  endtask
  task automatic pulses(input int len, input int n);
    repeat (n) begin
      repeat (300) @(posedge clk);
      ecu_u.pulse(len);
    end
  endtask
  task automatic fire(input int lo, input int hi);
    int i;
    for (i = 0; i < hi && line_oe !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    cmp(i >= lo && i < hi, 1);
    if (i >= hi) summarize();
    @(posedge clk);
    #1;
    ecu_u.per_q.delete();
  endtask
  task automatic wait_idle();
    int i;
    int q;
    q = 0;
    for (i = 0; i < 20000 && q < 500; i++) begin
      @(posedge clk);
      #1;
      q = (line_oe === 1'b0) ? q + 1 : 0;
    end
    if (q < 500) timeout();
  endtask
  // ==========================================
  // main sequence
  initial begin
    int i;
    int n;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    n = 0;
    mag_valid <= 1'b1;
    mag_data <= wd(0);
    for (i = 0; i < 200 && n < 32; i++) begin
      @(posedge clk);
      if (mag_ready === 1'b1) begin
        n++;
        mag_data <= wd(n);
      end
    end
    repeat (2) @(posedge clk);
    #1;
    cmp(n, 32);
    cmp(mag_ready, 1'b0);
    @(posedge clk);
    mag_valid <= 1'b0;
    $display("fifo fill test done");
    ocfg <= cfg(sft_pkg::MODE_STD, sft_pkg::SCN_SSM_A);
    get_per(n);
    for (i = 0; i < 4; i++) check_frame({i == 0, 1'b0, 2'h2}, wd(i), 1'b1);
    @(posedge clk);
    ocfg <= cfg(sft_pkg::MODE_TRIG_A, sft_pkg::SCN_SSM_A);
    check_frame(4'h6, wd(4), 1'b0);
    wait_idle();
    $display("free running test done");
    @(posedge clk);
    soft_err <= 1'b0;
    hard_err <= 1'b1;
    for (i = 0; i < 6; i++) begin
      @(posedge clk);
      ocfg <= cfg(md[i], i[0] ? 2'h1 : 2'h2);
      pulses(bl[i], bn[i]);
      if (bn[i] > 0) quiet(md[i] == sft_pkg::MODE_ADDR ? 4500 : 600);
      pulses(gl[i], gn[i]);
      fire(md[i] == sft_pkg::MODE_ADDR ? 3700 : 1, md[i] == sft_pkg::MODE_ADDR ? 3800 : 12);
      check_frame(i[0] ? 4'h1 : 4'h9, wd(5 + i), 1'b0);
      wait_idle();
      $display("trigger test %0d done", i);
    end
    cmp(ecu_u.low_bad, 0);
    summarize();
  end
endmodule
`default_nettype wire
